// ===== ars_defs.vh
// constants for the agent release sequencer
`ifndef ARS_DEFS_VH
`define ARS_DEFS_VH
// pressure input configuration codes
`define ARS_PCFG_NO 2'h0
`define ARS_PCFG_NC 2'h1
`define ARS_PCFG_MECH 2'h2
`define ARS_PCFG_NONE 2'h3
// timing at 100 MHz
`define ARS_CLK_HZ 100000000
`define ARS_TICK_HZ 1000
`define ARS_TICK_DIV (`ARS_CLK_HZ / `ARS_TICK_HZ)
`define ARS_ILOCK_MS 10000
`define ARS_FLASH_MS 500
`define ARS_STATIONS 4
`endif

// ===== ars_tick.v
// divider producing a one-cycle enable pulse every div cycles
module ars_tick #(
  parameter integer div = 100000
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // enable out
  output reg tick
);
  reg [31:0] cnt;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else if (cnt >= div - 1) begin
      cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== ars_timer.v
// millisecond down-counter: load, count on tick, done pulse at zero
module ars_timer #(
  parameter integer width = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire tick,
  input wire load,
  input wire clear,
  input wire [width-1:0] value,
  // status
  output reg running,
  output reg done
);
  reg [width-1:0] cnt;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= {width{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clear) begin
        running <= 1'b0;
      end else if (load) begin
        cnt <= value;
        running <= 1'b1;
        // a zero load expires at once
        if (value == {width{1'b0}}) begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end else if (running && tick) begin
        if (cnt <= {{(width-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - {{(width-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ===== ars_sequencer.v
// agent release sequencer: modes, discharge sequences and outputs
`include "ars_defs.vh"

// How it works
// - station inhibit press toggles auto/manual mode
// - up to four local stations handled
// - pressure input configurable: NO, NC, mechanical, none
// - mechanical option: active input reports manual release
// - manual mode: inhibit lamp, inoperative, no auto
// - station buzzer sounds while inhibit held in manual mode
// - entering manual aborts an unfired auto sequence, stages off
// - manual discharge needs lock-off open and button
// - manual order: lamp, brigade, stage1, stage2, delay, fire
// - pressure active lights discharge, then gas fired
// - manual release accepted in auto; inhibit no abort
// - single zone: steady lamp, stages, delay, fire
// - dual zone first alarm: flash lamp, stage1
// - dual zone second alarm: steady, stages, delay
// - service switch isolates release, inoperative, no override
// - lock-off operated: lamp and inoperative output
// - any fault lights common fault and buzzer
// - listed faults also raise brigade signal
// - circuit or zone fault asserts inoperative
// - zone isolated: lamp and inoperative output
// - unexplained pressure: stages on, release lamps, gas
// - active pressure means released, inactive means full
// - mechanical release needs prior inactive pressure
// - interlock off: lamp, override after ten seconds
module ars_sequencer #(
  parameter integer stations = `ARS_STATIONS,
  parameter integer tick_div = `ARS_TICK_DIV,
  parameter integer ilock_ms = `ARS_ILOCK_MS,
  parameter integer flash_ms = `ARS_FLASH_MS
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // local stations, one bit each
  input wire [stations-1:0] station_inhibit,
  input wire [stations-1:0] station_release,
  input wire [stations-1:0] station_fault,
  // host panel programming and commands
  input wire [1:0] pressure_cfg,
  input wire dual_zone,
  input wire delay_en,
  input wire [15:0] delay_ms,
  input wire panel_reset,
  // field inputs
  input wire [1:0] zone_alarm,
  input wire [1:0] zone_fault,
  input wire zone_isolated,
  input wire discharge_pressure_input,
  input wire interlock_on,
  input wire lockoff_operated,
  input wire service_switch,
  // monitor faults
  input wire pressure_mon_fault,
  input wire low_pressure_mon_fault,
  input wire lockoff_mon_fault,
  input wire circuit_fault,
  input wire stage1_fault,
  input wire stage2_fault,
  input wire interlock_fault,
  // outputs
  output reg manual_mode,
  output reg inhibit_lamp,
  output reg station_buzzer,
  output reg manual_lamp,
  output reg auto_lamp,
  output reg discharge_lamp,
  output reg lockoff_lamp,
  output reg zone_isolated_lamp,
  output reg interlock_lamp,
  output reg fault_lamp,
  output reg fault_buzzer,
  output reg brigade_alarm,
  output reg brigade_fault,
  output reg manual_release_event,
  output reg stage1,
  output reg stage2,
  output reg release_drive,
  output reg gas_fired,
  output reg system_inoperative
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] st_idle = 6'h01;
  localparam [5:0] st_first = 6'h02;
  localparam [5:0] st_delay = 6'h04;
  localparam [5:0] st_ilock = 6'h08;
  localparam [5:0] st_fired = 6'h10;
  localparam [5:0] st_mech = 6'h20;

  reg [5:0] state;
  reg [5:0] next_state;
  reg seq_manual;
  reg [stations-1:0] inh_prev;
  reg press_prev;
  reg full_seen;
  reg flash;
  wire tick;
  wire dly_done;
  wire il_done;
  wire flash_done;
  wire flash_run;
  reg dly_load;
  reg il_load;

  // ----------------------------------------------------------------
  // time base and timers
  // ----------------------------------------------------------------
  ars_tick #(.div(tick_div)) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  ars_timer #(.width(16)) u_delay (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .load(dly_load),
    .clear(panel_reset),
    .value(delay_en ? delay_ms : 16'h0000),
    .running(),
    .done(dly_done)
  );

  ars_timer #(.width(16)) u_ilock (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .load(il_load),
    .clear(panel_reset),
    .value(ilock_ms[15:0]),
    .running(),
    .done(il_done)
  );

  ars_timer #(.width(16)) u_flash (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .load(!flash_run),
    .clear(1'b0),
    .value(flash_ms[15:0]),
    .running(flash_run),
    .done(flash_done)
  );

  // ----------------------------------------------------------------
  // decoded inputs
  // ----------------------------------------------------------------
  // pressure input decode
  wire press_act = (pressure_cfg == `ARS_PCFG_NC) ?
    !discharge_pressure_input :
    (pressure_cfg == `ARS_PCFG_NONE) ? 1'b0 : discharge_pressure_input;
  // rising edge of any station inhibit
  wire inh_press = |(station_inhibit & ~inh_prev);
  wire next_mode = manual_mode ^ inh_press;
  // manual start: lock-off open, not in service
  wire man_req = |station_release && !lockoff_operated && !service_switch;
  wire any_alarm = |zone_alarm;
  wire both_alarm = &zone_alarm;
  // no automatic start in manual mode
  wire auto_ok = !next_mode && !service_switch;
  wire auto_go = auto_ok && (dual_zone ? both_alarm : any_alarm);
  // mechanical release only from a full cylinder
  wire mech_rise = press_act && !press_prev && full_seen;
  // pressure with no release fired by us
  wire unexplained = mech_rise && state != st_fired;

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    dly_load = 1'b0;
    il_load = 1'b0;
    case (state)
      st_idle: begin
        if (man_req) begin
          next_state = st_delay;
          dly_load = 1'b1;
        end else if (auto_go) begin
          next_state = st_delay;
          dly_load = 1'b1;
        end else if (auto_ok && dual_zone && any_alarm) begin
          next_state = st_first;
        end
      end
      st_first: begin
        if (man_req || auto_go) begin
          next_state = st_delay;
          dly_load = 1'b1;
        end
      end
      st_delay: begin
        if (dly_done) begin
          next_state = st_ilock;
          il_load = 1'b1;
        end
      end
      st_ilock: begin
        // fire on interlock or override, never in service
        if ((interlock_on || il_done) && !service_switch) begin
          next_state = st_fired;
        end
      end
      st_fired: begin
        next_state = st_fired;
      end
      st_mech: begin
        next_state = st_mech;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // inhibit aborts only an automatic sequence not yet fired
    if (inh_press && next_mode && !seq_manual &&
        (state == st_first || state == st_delay || state == st_ilock)) begin
      next_state = st_idle;
    end
    if (unexplained) begin
      next_state = st_mech;
    end
    if (panel_reset) begin
      next_state = st_idle;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  wire any_fault = pressure_mon_fault | low_pressure_mon_fault |
    lockoff_mon_fault | circuit_fault | stage1_fault | stage2_fault |
    (|zone_fault) | interlock_fault | (|station_fault);
  wire brig_fault = pressure_mon_fault | low_pressure_mon_fault |
    lockoff_mon_fault | stage1_fault | stage2_fault | interlock_fault;
  wire run = next_state == st_delay || next_state == st_ilock ||
    next_state == st_fired || next_state == st_mech;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      seq_manual <= 1'b0;
      inh_prev <= {stations{1'b0}};
      press_prev <= 1'b0;
      full_seen <= 1'b0;
      flash <= 1'b0;
      manual_mode <= 1'b0;
      inhibit_lamp <= 1'b0;
      station_buzzer <= 1'b0;
      manual_lamp <= 1'b0;
      auto_lamp <= 1'b0;
      discharge_lamp <= 1'b0;
      lockoff_lamp <= 1'b0;
      zone_isolated_lamp <= 1'b0;
      interlock_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      fault_buzzer <= 1'b0;
      brigade_alarm <= 1'b0;
      brigade_fault <= 1'b0;
      manual_release_event <= 1'b0;
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      release_drive <= 1'b0;
      gas_fired <= 1'b0;
      system_inoperative <= 1'b0;
    end else begin
      state <= next_state;
      inh_prev <= station_inhibit;
      press_prev <= press_act;
      if (flash_done) begin
        flash <= !flash;
      end
      // full cylinder seen while pressure inactive
      if (!press_act) begin
        full_seen <= 1'b1;
      end else if (mech_rise) begin
        full_seen <= 1'b0;
      end
      manual_mode <= next_mode;
      inhibit_lamp <= next_mode;
      // buzzer while held in manual mode
      station_buzzer <= next_mode && |station_inhibit;
      if ((state == st_idle || state == st_first) && man_req) begin
        seq_manual <= 1'b1;
        manual_lamp <= 1'b1;
        brigade_alarm <= 1'b1;
      end
      if (next_state == st_first) begin
        auto_lamp <= flash;
      end else if (run && !seq_manual && !(state == st_idle && man_req)) begin
        auto_lamp <= 1'b1;
      end
      stage1 <= next_state != st_idle;
      stage2 <= run;
      release_drive <= next_state == st_fired && !service_switch;
      // interlock lamp while waiting on it
      interlock_lamp <= next_state == st_ilock && !interlock_on;
      if ((state == st_fired && press_act) || unexplained ||
          (state == st_fired && pressure_cfg == `ARS_PCFG_NONE)) begin
        discharge_lamp <= 1'b1;
      end
      if (discharge_lamp) begin
        gas_fired <= 1'b1;
      end
      // manual release report when mechanical selected
      manual_release_event <= unexplained &&
        pressure_cfg == `ARS_PCFG_MECH;
      if (unexplained && pressure_cfg == `ARS_PCFG_MECH) begin
        brigade_alarm <= 1'b1;
      end
      lockoff_lamp <= lockoff_operated;
      zone_isolated_lamp <= zone_isolated;
      fault_lamp <= any_fault;
      fault_buzzer <= any_fault;
      brigade_fault <= brig_fault;
      system_inoperative <= next_mode | service_switch | lockoff_operated |
        circuit_fault | (|zone_fault) | zone_isolated;
      // abort clears the auto lamp; reset also clears the latched indications
      if (next_state == st_idle) begin
        seq_manual <= 1'b0;
        auto_lamp <= 1'b0;
        if (panel_reset) begin
          manual_lamp <= 1'b0;
          brigade_alarm <= 1'b0;
          discharge_lamp <= 1'b0;
          gas_fired <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== ars_seq_assertions.sv
// assertion checker bound to the agent release sequencer
module ars_seq_assertions #(
  parameter integer stations = 4
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // watched inputs
  input wire [stations-1:0] station_inhibit,
  input wire service_switch,
  input wire lockoff_operated,
  input wire pressure_mon_fault,
  input wire circuit_fault,
  // watched outputs
  input wire manual_mode,
  input wire inhibit_lamp,
  input wire station_buzzer,
  input wire fault_lamp,
  input wire brigade_fault,
  input wire lockoff_lamp,
  input wire system_inoperative,
  input wire release_drive,
  input wire discharge_lamp,
  input wire gas_fired
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_gas_up;
    !gas_fired ##1 gas_fired;
  endsequence
  property p_tog;
    |(station_inhibit & ~$past(station_inhibit))
      |=> manual_mode != $past(manual_mode);
  endproperty
  a_tog: assert property (p_tog) else $error("mode not toggled");
  property p_lamp;
    inhibit_lamp == manual_mode;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp off mode");
  property p_buz;
    manual_mode && |station_inhibit && $stable(station_inhibit)
      |=> station_buzzer;
  endproperty
  a_buz: assert property (p_buz) else $error("buzzer silent");
  property p_quiet;
    !(|station_inhibit) |=> !station_buzzer;
  endproperty
  a_quiet: assert property (p_quiet) else $error("buzzer on");
  property p_svc;
    service_switch |=> !release_drive && system_inoperative;
  endproperty
  a_svc: assert property (p_svc) else $error("service not held");
  property p_lock;
    lockoff_operated |=> lockoff_lamp && system_inoperative;
  endproperty
  a_lock: assert property (p_lock) else $error("lock-off missed");
  property p_flt;
    pressure_mon_fault |=> fault_lamp && brigade_fault;
  endproperty
  a_flt: assert property (p_flt) else $error("fault missed");
  property p_cf;
    circuit_fault |=> fault_lamp && system_inoperative;
  endproperty
  a_cf: assert property (p_cf) else $error("circuit fault missed");
  property p_gas;
    s_gas_up |-> $past(discharge_lamp);
  endproperty
  a_gas: assert property (p_gas) else $error("gas before lamp");
endmodule

bind ars_sequencer ars_seq_assertions #(.stations(stations)) u_chk (
  .core_clk, .rst, .station_inhibit, .service_switch, .lockoff_operated,
  .pressure_mon_fault, .circuit_fault, .manual_mode, .inhibit_lamp,
  .station_buzzer, .fault_lamp, .brigade_fault, .lockoff_lamp,
  .system_inoperative, .release_drive, .discharge_lamp, .gas_fired
);

// ===== ars_valve_model.sv
// model of the agent valve and its pressure contact
module ars_valve_model (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire release_drive,
  input wire slow,
  input wire force_mech,
  input wire refill,
  // contact, high while agent released
  output logic pressure
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // valve
  // ------------------------------------------------------------
  int cnt;
  always @(posedge core_clk or posedge rst) begin
    if (rst || refill) begin
      pressure <= 1'h0;
      cnt <= 0;
    end else if (force_mech) begin
      pressure <= 1'h1;
    end else if (release_drive && !pressure) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 20 : 2)) begin
        pressure <= 1'h1;
      end
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the agent release sequencer
`include "ars_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk = 1'h0, rst = 1'h1, ev = 1'h0;
  logic [3:0] station_inhibit = 4'h0, station_release = 4'h0;
  logic [1:0] pressure_cfg = 2'h0, zone_alarm = 2'h0;
  logic dual_zone = 1'h0, delay_en = 1'h0, panel_reset = 1'h0;
  logic interlock_on = 1'h1, slow = 1'h0, force_mech = 1'h0;
  logic refill = 1'h0, il_seen = 1'h0;
  logic [15:0] delay_ms = 16'h0003;
  logic [11:0] fin = 12'h000;
  logic [16:0] tab [12];
  int err_count = 0, compares = 0, n;
  wire pr;
  wire service_switch = fin[0], lockoff_operated = fin[1];
  wire zone_isolated = fin[2], circuit_fault = fin[4];
  wire [1:0] zone_fault = {1'h0, fin[3]};
  wire pressure_mon_fault = fin[5], low_pressure_mon_fault = fin[6];
  wire lockoff_mon_fault = fin[7], stage1_fault = fin[8];
  wire stage2_fault = fin[9], interlock_fault = fin[10];
  wire [3:0] station_fault = {3'h0, fin[11]};
  wire manual_mode, inhibit_lamp, station_buzzer, manual_lamp, auto_lamp;
  wire discharge_lamp, lockoff_lamp, zone_isolated_lamp, interlock_lamp;
  wire fault_lamp, fault_buzzer, brigade_alarm, brigade_fault, stage1;
  wire manual_release_event, stage2, release_drive, gas_fired;
  wire system_inoperative;
  wire discharge_pressure_input = (pressure_cfg == `ARS_PCFG_NC) ? ~pr : pr;
  wire [4:0] obs = {gas_fired, release_drive, discharge_lamp, stage2, stage1};

  // small counts keep the run short
  ars_sequencer #(.tick_div(4), .ilock_ms(10), .flash_ms(2)) dut (
    .core_clk, .rst, .station_inhibit, .station_release, .station_fault,
    .pressure_cfg, .dual_zone, .delay_en, .delay_ms, .panel_reset,
    .zone_alarm, .zone_fault, .zone_isolated, .discharge_pressure_input,
    .interlock_on, .lockoff_operated, .service_switch, .pressure_mon_fault,
    .low_pressure_mon_fault, .lockoff_mon_fault, .circuit_fault,
    .stage1_fault, .stage2_fault, .interlock_fault, .manual_mode,
    .inhibit_lamp, .station_buzzer, .manual_lamp, .auto_lamp,
    .discharge_lamp, .lockoff_lamp, .zone_isolated_lamp, .interlock_lamp,
    .fault_lamp, .fault_buzzer, .brigade_alarm, .brigade_fault,
    .manual_release_event, .stage1, .stage2, .release_drive, .gas_fired,
    .system_inoperative
  );
  ars_valve_model pm (
    .core_clk, .rst, .release_drive, .slow, .force_mech, .refill,
    .pressure(pr)
  );

  always #5 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task tk(int c);
    repeat (c) @(posedge core_clk);
  endtask
  task tally_and_finish;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // waits on one obs bit; n returns the cycles taken
  task wt(int k, int lim);
    n = 0;
    while (obs[k] !== 1'h1) begin
      tk(1);
      #1;
      ev |= manual_release_event;
      il_seen |= interlock_lamp;
      n++;
      if (n > lim) begin
        $display("[FAIL] wait on obs %0d expected 1 seen 0", k);
        err_count++;
        tally_and_finish();
      end
    end
  endtask
  task cnt(int c);
    n = 0;
    repeat (c) begin
      tk(1);
      #1;
      n += int'(auto_lamp === 1'h1);
    end
  endtask
  // drain the cylinder contact first, else it reads as released
  task rearm;
    tk(1);
    zone_alarm <= 2'h0;
    interlock_on <= 1'h1;
    refill <= 1'h1;
    tk(1);
    refill <= 1'h0;
    panel_reset <= 1'h1;
    tk(1);
    panel_reset <= 1'h0;
    tk(2);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    tab = '{{12'h001, 5'h10}, {12'h002, 5'h18}, {12'h004, 5'h14},
      {12'h008, 5'h12}, {12'h010, 5'h12}, {12'h020, 5'h03},
      {12'h040, 5'h03}, {12'h080, 5'h03}, {12'h100, 5'h03},
      {12'h200, 5'h03}, {12'h400, 5'h03}, {12'h800, 5'h02}};
    tk(12);
    rst <= 1'h0;
    tk(1);
    #1;
    chk("idle", 1'h0, |{manual_mode, stage1, system_inoperative});
    tk(1);
    foreach (tab[i]) begin
      fin <= tab[i][16:5];
      tk(1);
      #1;
      chk("inoperative", tab[i][4], system_inoperative);
      chk("lockoff lamp", tab[i][3], lockoff_lamp);
      chk("isolated lamp", tab[i][2], zone_isolated_lamp);
      chk("fault lamp", tab[i][1], fault_lamp);
      chk("fault buzzer", tab[i][1], fault_buzzer);
      chk("brigade fault", tab[i][0], brigade_fault);
      tk(1);
    end
    fin <= 12'h000;
    station_inhibit <= 4'h8;
    tk(2);
    #1;
    chk("manual mode", 1'h1, manual_mode);
    chk("inhibit lamp", 1'h1, inhibit_lamp);
    chk("inoperative", 1'h1, system_inoperative);
    chk("buzzer", 1'h1, station_buzzer);
    tk(1);
    station_inhibit <= 4'h0;
    zone_alarm <= 2'h1;
    tk(4);
    #1;
    chk("buzzer off", 1'h0, station_buzzer);
    chk("auto refused", 1'h0, stage1);
    tk(1);
    station_inhibit <= 4'h1;
    zone_alarm <= 2'h0;
    tk(1);
    station_inhibit <= 4'h0;
    delay_en <= 1'h1;
    interlock_on <= 1'h0;
    zone_alarm <= 2'h1;
    tk(2);
    #1;
    chk("auto lamp", 1'h1, auto_lamp);
    chk("stage2", 1'h1, stage2);
    wt(3, 200);
    chk("delay and override", 1'h1, n >= 40);
    chk("interlock lamp", 1'h1, il_seen);
    chk("interlock lamp off", 1'h0, interlock_lamp);
    wt(4, 20);
    chk("discharge lamp", 1'h1, discharge_lamp);
    rearm;
    chk("reset clears", 1'h0, |obs);
    dual_zone <= 1'h1;
    delay_en <= 1'h0;
    zone_alarm <= 2'h1;
    tk(2);
    #1;
    chk("stage1 only", 1'h1, stage1 & ~stage2);
    cnt(12);
    chk("lamp flashes", 1'h1, n > 0 && n < 12);
    tk(1);
    station_inhibit <= 4'h2;
    tk(1);
    station_inhibit <= 4'h0;
    tk(1);
    #1;
    chk("aborted", 1'h0, stage1 | stage2);
    tk(1);
    station_inhibit <= 4'h2;
    zone_alarm <= 2'h0;
    tk(1);
    station_inhibit <= 4'h0;
    zone_alarm <= 2'h3;
    wt(3, 50);
    chk("second zone", 1'h1, stage2);
    cnt(6);
    chk("lamp steady", 1'h1, n == 6);
    rearm;
    fin <= 12'h002;
    station_release <= 4'h8;
    tk(3);
    #1;
    chk("lockoff refuses", 1'h0, stage1);
    tk(1);
    fin <= 12'h001;
    station_release <= 4'h0;
    tk(1);
    station_release <= 4'h8;
    tk(3);
    #1;
    chk("service refuses", 1'h0, stage1);
    tk(1);
    station_release <= 4'h0;
    tk(1);
    fin <= 12'h000;
    station_release <= 4'h1;
    tk(1);
    station_release <= 4'h0;
    station_inhibit <= 4'h1;
    fin <= 12'h001;
    #1;
    chk("manual start", 1'h1, manual_lamp & brigade_alarm & stage2);
    tk(1);
    station_inhibit <= 4'h0;
    tk(40);
    #1;
    chk("no abort", 1'h1, stage1);
    chk("isolated", 1'h0, release_drive);
    tk(1);
    fin <= 12'h000;
    wt(3, 20);
    for (int c = 0; c < 4; c++) begin
      rearm;
      pressure_cfg <= 2'(c);
      tk(3);
      ev = 1'h0;
      force_mech <= 1'h1;
      tk(1);
      force_mech <= 1'h0;
      if (c == 3) begin
        tk(20);
        #1;
        chk("not fitted", 1'h0, stage1 | gas_fired);
      end else begin
        wt(4, 20);
        chk("mech stages", 1'h1, stage1 & stage2);
        chk("mech report", c == 2, ev);
      end
    end
    tally_and_finish();
  end
endmodule
